// File: logic/afe_pkg.sv
// afe_pkg: constants of the front-end serial port.
// assumes one system clock that also serves as the master clock.
package afe_pkg;
    localparam int AFE_WORD_BITS = 16;
    localparam int AFE_DIV_W = 4;
    localparam logic [AFE_DIV_W-1:0] AFE_MCLK_DIV_RST = 4'h1;
    localparam logic [AFE_DIV_W-1:0] AFE_SCLK_DIV_RST = 4'h8;
    // smallest divisor; keeps sampled pins ahead of the internal edges
    localparam logic [2*AFE_DIV_W-1:0] AFE_MIN_DIV = 8'h08;

    typedef enum logic [1:0] {
        AFE_TX_IDLE = 2'b00,
        AFE_TX_ARMED = 2'b01,
        AFE_TX_SHIFT = 2'b10
    } afe_tx_state_type;

    typedef enum logic [0:0] {
        AFE_RX_IDLE = 1'b0,
        AFE_RX_SHIFT = 1'b1
    } afe_rx_state_type;

    // second and third stage agree: accept, else hold old value
    function automatic logic afe_agree(input logic s2, input logic s3,
                                       input logic old);
        afe_agree = (s2 == s3) ? s3 : old;
    endfunction

    function automatic logic [2*AFE_DIV_W-1:0] afe_eff_div(
        input logic [AFE_DIV_W-1:0] m, input logic [AFE_DIV_W-1:0] s);
        logic [2*AFE_DIV_W-1:0] p;
        p = m * s;
        afe_eff_div = (p < AFE_MIN_DIV) ? AFE_MIN_DIV : p;
    endfunction
endpackage

// File: logic/afe_div_if.sv
// afe_div_if: ticks between serial clock divider and port logic.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface afe_div_if #(parameter int DW = 8);
    logic run;
    logic [DW-1:0] divisor;
    logic tick_rise;
    logic tick_fall;
    modport div (input run, input divisor, output tick_rise, output tick_fall);
    modport port (output run, output divisor, input tick_rise,
                  input tick_fall);
endinterface
`default_nettype wire

// File: logic/afe_sclk_div.sv
// afe_sclk_div: serial clock divider producing rise and fall ticks.
// assumes divisor is at least two and stable while running.
`timescale 1ns/1ps
`default_nettype none
module afe_sclk_div #(
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // divider link
    afe_div_if.div dv
);
    import afe_pkg::*;

    logic [DW-1:0] cnt_ff;
    logic [DW-1:0] half;

    assign half = dv.divisor >> 1;
    assign dv.tick_rise = dv.run && (cnt_ff == '0);
    assign dv.tick_fall = dv.run && (cnt_ff == half);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (!dv.run) begin
            cnt_ff <= '0;
        end else if (cnt_ff >= dv.divisor - 1'b1) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    div_period_a: assert property (@(posedge clk) disable iff (!resetn)
        dv.tick_rise && dv.run |=> !dv.tick_rise [*1] ##0
            (cnt_ff == 1 || !dv.run))
        else $error("rise tick not followed by count one");

    div_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        !dv.run |=> cnt_ff == '0)
        else $error("divider kept counting while stopped");
endmodule
`default_nettype wire

// File: logic/afe_serial_port.sv
// afe_serial_port: front-end serial port, serial side and word side.
// assumes clk is the master clock; port pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module afe_serial_port #(
    parameter int WORD_BITS = afe_pkg::AFE_WORD_BITS,
    parameter int DIV_W = afe_pkg::AFE_DIV_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // divider configuration
    input wire logic cfg_load,
    input wire logic [DIV_W-1:0] cfg_mclk_div,
    input wire logic [DIV_W-1:0] cfg_sclk_div,
    // transmit words
    input wire logic tx_valid,
    input wire logic [WORD_BITS-1:0] tx_word,
    output logic tx_ready,
    // received words
    output logic rx_valid,
    output logic [WORD_BITS-1:0] rx_word,
    // serial pins
    input wire logic port_enable,
    output logic port_serial_clock,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic out_frame_sync,
    output logic out_frame_sync_oe,
    input wire logic in_frame_sync,
    input wire logic serial_data_in
);
    import afe_pkg::*;

    localparam int CW = $clog2(WORD_BITS);
    localparam logic [CW-1:0] LAST_BIT = CW'(WORD_BITS - 1);

    afe_div_if #(.DW(2*DIV_W)) dv ();

    afe_sclk_div #(.DW(2*DIV_W)) u_div (
        .clk(clk),
        .resetn(resetn),
        .dv(dv)
    );

    logic [2:0] pe_sync_ff, ifs_sync_ff, sdi_sync_ff;
    logic pe_ff, ifs_ff, sdi_ff;
    logic [DIV_W-1:0] mclk_div_ff, sclk_div_ff;
    logic [WORD_BITS-1:0] tx_buf_ff, rx_shift_ff, rx_word_ff;
    logic [CW-1:0] tx_cnt_ff, rx_cnt_ff;
    afe_tx_state_type tx_state_ff, nxt_tx_state;
    afe_rx_state_type rx_state_ff;
    logic sclk_ff, sdo_ff, sdo_oe_ff, ofs_ff, ofs_oe_ff;
    logic tx_ready_ff, rx_valid_ff;

    // pin synchronisers, three stages each
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pe_sync_ff <= 3'h0;
            ifs_sync_ff <= 3'h0;
            sdi_sync_ff <= 3'h0;
            pe_ff <= 1'b0;
            ifs_ff <= 1'b0;
            sdi_ff <= 1'b0;
        end else begin
            pe_sync_ff <= {pe_sync_ff[1:0], port_enable};
            ifs_sync_ff <= {ifs_sync_ff[1:0], in_frame_sync};
            sdi_sync_ff <= {sdi_sync_ff[1:0], serial_data_in};
            pe_ff <= afe_agree(pe_sync_ff[1], pe_sync_ff[2], pe_ff);
            ifs_ff <= afe_agree(ifs_sync_ff[1], ifs_sync_ff[2], ifs_ff);
            sdi_ff <= afe_agree(sdi_sync_ff[1], sdi_sync_ff[2], sdi_ff);
        end
    end

    // control registers set to their defaults by reset only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mclk_div_ff <= AFE_MCLK_DIV_RST;
            sclk_div_ff <= AFE_SCLK_DIV_RST;
        end else if (cfg_load) begin
            mclk_div_ff <= cfg_mclk_div;
            sclk_div_ff <= cfg_sclk_div;
        end
    end

    assign dv.divisor = afe_eff_div(mclk_div_ff, sclk_div_ff);
    assign dv.run = pe_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_ff <= 1'b0;
        end else if (!pe_ff) begin
            sclk_ff <= 1'b0;
        end else if (dv.tick_rise) begin
            sclk_ff <= 1'b1;
        end else if (dv.tick_fall) begin
            sclk_ff <= 1'b0;
        end
    end

    // transmit sequencing
    always_comb begin
        nxt_tx_state = tx_state_ff;
        case (tx_state_ff)
            AFE_TX_IDLE: begin
                if (tx_valid && tx_ready_ff) begin
                    nxt_tx_state = AFE_TX_ARMED;
                end
            end
            AFE_TX_ARMED: begin
                if (dv.tick_rise) begin
                    nxt_tx_state = AFE_TX_SHIFT;
                end
            end
            AFE_TX_SHIFT: begin
                if (dv.tick_rise && tx_cnt_ff == LAST_BIT && !ofs_ff) begin
                    nxt_tx_state = AFE_TX_IDLE;
                end
            end
            default: nxt_tx_state = AFE_TX_IDLE;
        endcase
        // state returns to reset on disable
        if (!pe_ff) begin
            nxt_tx_state = AFE_TX_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_ff <= AFE_TX_IDLE;
            tx_ready_ff <= 1'b0;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tx_ready_ff <= pe_ff && nxt_tx_state == AFE_TX_IDLE;
        end
    end

    // any word, data or control, is framed the same
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_buf_ff <= '0;
        end else if (tx_valid && tx_ready_ff && tx_state_ff == AFE_TX_IDLE) begin
            tx_buf_ff <= tx_word;
        end else if (tx_state_ff == AFE_TX_SHIFT && dv.tick_rise) begin
            tx_buf_ff <= {tx_buf_ff[WORD_BITS-2:0], 1'b0};
        end
    end

    // data and sync launched on rising ticks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
            ofs_ff <= 1'b0;
            tx_cnt_ff <= '0;
        end else if (!pe_ff) begin
            sdo_oe_ff <= 1'b0;
            ofs_ff <= 1'b0;
            tx_cnt_ff <= '0;
        end else if (dv.tick_rise) begin
            // one bit period of sync before msb
            ofs_ff <= tx_state_ff == AFE_TX_ARMED;
            if (tx_state_ff == AFE_TX_SHIFT) begin
                sdo_ff <= tx_buf_ff[WORD_BITS-1];
                sdo_oe_ff <= 1'b1;
                tx_cnt_ff <= ofs_ff ? '0 : tx_cnt_ff + 1'b1;
                if (!ofs_ff && tx_cnt_ff == LAST_BIT) begin
                    sdo_oe_ff <= 1'b0;
                end
            end else begin
                sdo_oe_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ofs_oe_ff <= 1'b0;
        end else begin
            ofs_oe_ff <= pe_ff;
        end
    end

    // sync and data sampled on falling ticks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_ff <= AFE_RX_IDLE;
            rx_cnt_ff <= '0;
            rx_shift_ff <= '0;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= 1'b0;
            if (!pe_ff) begin
                rx_state_ff <= AFE_RX_IDLE;
                rx_cnt_ff <= '0;
            end else if (dv.tick_fall) begin
                if (ifs_ff) begin
                    rx_state_ff <= AFE_RX_SHIFT;
                    rx_cnt_ff <= '0;
                end else if (rx_state_ff == AFE_RX_SHIFT) begin
                    rx_shift_ff <= {rx_shift_ff[WORD_BITS-2:0], sdi_ff};
                    rx_cnt_ff <= rx_cnt_ff + 1'b1;
                    if (rx_cnt_ff == LAST_BIT) begin
                        rx_state_ff <= AFE_RX_IDLE;
                        rx_valid_ff <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_word_ff <= '0;
        end else if (pe_ff && dv.tick_fall && !ifs_ff &&
                     rx_state_ff == AFE_RX_SHIFT && rx_cnt_ff == LAST_BIT) begin
            rx_word_ff <= {rx_shift_ff[WORD_BITS-2:0], sdi_ff};
        end
    end

    assign tx_ready = tx_ready_ff;
    assign rx_valid = rx_valid_ff;
    assign rx_word = rx_word_ff;
    assign port_serial_clock = sclk_ff;
    assign serial_data_out = sdo_ff;
    assign serial_data_out_oe = sdo_oe_ff;
    assign out_frame_sync = ofs_ff;
    assign out_frame_sync_oe = ofs_oe_ff;

    reset_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> !sdo_oe_ff && !ofs_ff && !rx_valid_ff &&
            mclk_div_ff == AFE_MCLK_DIV_RST)
        else $error("outputs not cleared by reset");

    sdo_rise_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(sdo_ff) |-> $past(dv.tick_rise) && $past(pe_ff))
        else $error("data out changed off a rising tick");

    sdo_release_a: assert property (@(posedge clk) disable iff (!resetn)
        !pe_ff |=> !sdo_oe_ff)
        else $error("data out driven while disabled");

    sync_msb_a: assert property (@(posedge clk) disable iff (!resetn)
        ofs_ff && dv.tick_rise && pe_ff |=> !ofs_ff && sdo_oe_ff &&
            sdo_ff == $past(tx_buf_ff[WORD_BITS-1]))
        else $error("msb did not follow frame sync");

    sync_launch_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(ofs_ff) |-> $past(dv.tick_rise) || !$past(pe_ff))
        else $error("frame sync changed off a rising tick");

    rx_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
        !pe_ff |=> rx_state_ff == AFE_RX_IDLE && !rx_valid_ff)
        else $error("receiver active while disabled");

    rx_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        rx_valid_ff |-> $past(dv.tick_fall) && $past(pe_ff))
        else $error("word completed off a falling tick");

    clk_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        !pe_ff |-> !dv.tick_rise && !dv.tick_fall ##1 !sclk_ff)
        else $error("serial clock ran while disabled");

    rx_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        pe_ff && dv.tick_fall && ifs_ff |=> rx_cnt_ff == '0 &&
            rx_state_ff == AFE_RX_SHIFT)
        else $error("frame sync did not restart bit count");
endmodule
`default_nettype wire

// File: verification/afe_partner.sv
// afe_partner: processor-side serial port model facing the front end.
// assumes the front end drives serial clock and out frame sync.
`timescale 1ns/1ps
`default_nettype none
module afe_partner (
    // serial pins
    input wire logic port_serial_clock,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic out_frame_sync,
    input wire logic out_frame_sync_oe,
    output logic in_frame_sync,
    output var logic serial_data_in,
    // bench control
    input wire logic hold_sync
);
    logic sending = 1'b0;
    logic sync_ff = 1'b0;
    logic [15:0] shift_ff = 16'h0000;
    int cnt = 0;
    logic [15:0] got_q[$];
    assign in_frame_sync = sync_ff | hold_sync;
    initial serial_data_in = 1'b0;
    always @(posedge port_serial_clock) begin
        if (!sending) begin
            serial_data_in <= ~serial_data_in;
        end
    end
    task automatic send(input logic [15:0] w);
        sending = 1'b1;
        @(posedge port_serial_clock);
        sync_ff <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge port_serial_clock);
            sync_ff <= 1'b0;
            serial_data_in <= w[i];
        end
        @(posedge port_serial_clock);
        sending = 1'b0;
    endtask
    // capture on falling edge after sync
    always @(negedge port_serial_clock) begin
        if (out_frame_sync_oe && out_frame_sync) begin
            cnt = 16;
        end else if (cnt > 0 && !serial_data_out_oe) begin
            cnt = 0;
        end else if (cnt > 0) begin
            shift_ff = {shift_ff[14:0], serial_data_out};
            cnt--;
            if (cnt == 0) begin
                got_q.push_back(shift_ff);
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/test_afe_serial_port.sv
// test_afe_serial_port: self-checking bench of the front-end serial port.
// assumes the partner model answers on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module test_afe_serial_port;
    import afe_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cfg_load = 1'b0;
    logic [AFE_DIV_W-1:0] cfg_mclk_div = 4'h1;
    logic [AFE_DIV_W-1:0] cfg_sclk_div = 4'h8;
    logic tx_valid = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic tx_ready, rx_valid, port_serial_clock;
    logic [15:0] rx_word;
    logic port_enable = 1'b1;
    logic serial_data_out, serial_data_out_oe, out_frame_sync;
    logic out_frame_sync_oe, in_frame_sync, serial_data_in;
    logic hold_sync = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    int rx_cnt = 0;
    afe_serial_port u_afe_serial_port (
        .clk(clk), .resetn(resetn), .cfg_load(cfg_load),
        .cfg_mclk_div(cfg_mclk_div), .cfg_sclk_div(cfg_sclk_div),
        .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_word(rx_word), .port_enable(port_enable),
        .port_serial_clock(port_serial_clock),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe),
        .out_frame_sync(out_frame_sync),
        .out_frame_sync_oe(out_frame_sync_oe),
        .in_frame_sync(in_frame_sync), .serial_data_in(serial_data_in)
    );
    afe_partner u_afe_partner (
        .port_serial_clock(port_serial_clock),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe),
        .out_frame_sync(out_frame_sync),
        .out_frame_sync_oe(out_frame_sync_oe),
        .in_frame_sync(in_frame_sync), .serial_data_in(serial_data_in),
        .hold_sync(hold_sync)
    );
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (rx_valid === 1'b1) rx_cnt++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_ready();
        #1;
        for (int k = 0; k < 3000 && tx_ready !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (tx_ready !== 1'b1) begin
            num_errors++;
            $display("BAD t=%0t ready never came", $time);
            results();
        end
    endtask
    task automatic wait_got(input int n);
        for (int k = 0; k < 2000 && u_afe_partner.got_q.size() < n; k++)
            @(posedge clk);
        if (u_afe_partner.got_q.size() < n) begin
            num_errors++;
            $display("BAD t=%0t partner got too few words", $time);
            results();
        end
    endtask
    task automatic send_word(input logic [15:0] w);
        wait_ready();
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_word <= w;
        @(posedge clk);
        while (tx_ready !== 1'b1) @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    task automatic period_is(input int exp);
        realtime t0;
        @(posedge port_serial_clock);
        t0 = $realtime;
        @(posedge port_serial_clock);
        check(16'(int'(($realtime - t0) / 100.0)), 16'(exp));
    endtask
    function automatic logic [15:0] idle_pins();
        return {11'h000, tx_ready, rx_valid, port_serial_clock,
                serial_data_out_oe, out_frame_sync_oe};
    endfunction
    task automatic t_reset();
        repeat (8) @(posedge clk);
        check(idle_pins(), 16'h0000);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        wait_ready();
        period_is(8);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_mclk_div <= 4'h3;
        cfg_sclk_div <= 4'h4;
        @(posedge clk);
        cfg_load <= 1'b0;
        repeat (30) @(posedge clk);
        period_is(12);
        $display("test reset and divider done");
    endtask
    task automatic t_tx();
        logic seen;
        seen = 1'b0;
        u_afe_partner.got_q.delete();
        send_word(16'ha53c);
        send_word(16'h8001);
        wait_got(2);
        check(u_afe_partner.got_q[0], 16'ha53c);
        check(u_afe_partner.got_q[1], 16'h8001);
        wait_ready();
        repeat (24) begin
            @(posedge clk);
            #1;
            seen |= serial_data_out_oe | out_frame_sync;
        end
        check(16'(seen), 16'h0000);
        $display("test transmit done");
    endtask
    task automatic t_duplex();
        int c0;
        c0 = rx_cnt;
        u_afe_partner.got_q.delete();
        fork
            u_afe_partner.send(16'h3cc3);
            send_word(16'h5a0f);
        join
        wait_got(1);
        repeat (20) @(posedge clk);
        check(rx_word, 16'h3cc3);
        check(16'(rx_cnt - c0), 16'h0001);
        check(u_afe_partner.got_q[0], 16'h5a0f);
        $display("test duplex done");
    endtask
    task automatic t_disable();
        int c0;
        logic [15:0] seen;
        c0 = rx_cnt;
        seen = 16'h0000;
        @(posedge clk);
        port_enable <= 1'b0;
        hold_sync <= 1'b1;
        repeat (10) @(posedge clk);
        repeat (100) begin
            @(posedge clk);
            #1;
            seen |= idle_pins();
        end
        check(seen, 16'h0000);
        @(posedge clk);
        hold_sync <= 1'b0;
        repeat (10) @(posedge clk);
        port_enable <= 1'b1;
        period_is(12);
        check(16'(rx_cnt - c0), 16'h0000);
        check(rx_word, 16'h3cc3);
        $display("test disable done");
    endtask
    task automatic t_abort();
        u_afe_partner.got_q.delete();
        send_word(16'hffff);
        repeat (60) @(posedge clk);
        port_enable <= 1'b0;
        repeat (20) @(posedge clk);
        port_enable <= 1'b1;
        wait_ready();
        check(16'(tx_ready), 16'h0001);
        send_word(16'h0f0f);
        wait_got(1);
        check(u_afe_partner.got_q[0], 16'h0f0f);
        $display("test abort done");
    endtask
    task automatic t_reset2();
        send_word(16'h1234);
        repeat (50) @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        check(idle_pins(), 16'h0000);
        check(rx_word, 16'h0000);
        resetn <= 1'b1;
        wait_ready();
        period_is(8);
        $display("test second reset done");
    endtask
    initial begin
        t_reset();
        t_tx();
        t_duplex();
        t_disable();
        t_abort();
        t_reset2();
        results();
    end
    initial begin
        #(3_000_000);
        num_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
